// ---- device_class_cell.sv ----
// one class of device memory: storage word plus its clear/initialise/keep decision
// assumes events arrive as one-cycle codes from the retention sequencer
`timescale 1ns/1ns
`include "device_memory_retention_map.svh"
module device_class_cell #(
    parameter int unsigned DW       = 16,
    parameter logic [11:0] TBL      = `TBL_GENERAL,
    parameter logic [15:0] INIT_VAL = `SPECIAL_INIT
) (
    input  wire logic                               clk_i,        // system clock
    input  wire logic                               rst_i,        // power-on reset
    input  wire device_memory_retention_pkg::event_type event_i,  // event being applied
    input  wire logic                               hold_i,       // memory hold in stop
    input  wire logic                               as_general_i, // latched range made general
    input  wire logic                               backup_lost_i,// battery failed while off
    input  wire logic                               latch_clr_i,  // end-of-scan latch clear
    input  wire logic                               latch_block_i,// latched devices may not be set
    input  wire logic                               wr_i,         // bus write strobe
    input  wire logic [1:0]                         be_i,         // byte enables
    input  wire logic [DW-1:0]                      wdata_i,      // write data
    output logic      [DW-1:0]                      rdata_o       // stored value
);

    logic [DW-1:0] data_reg;
    logic [DW-1:0] data_next;
    logic [11:0]   eff_tbl;
    logic [1:0]    act;
    logic          latched;

    always_comb begin
        // a reassigned latched class follows the general pattern; fixed ones ignore it
        eff_tbl = (TBL[`F_CFG] && as_general_i) ? `TBL_GENERAL : TBL;
        latched = eff_tbl[`F_LATCHED];
        act = `ACT_KEEP;
        unique case (event_i)
            device_memory_retention_pkg::EV_NONE:    act = `ACT_KEEP;
            device_memory_retention_pkg::EV_LOSS:    act = eff_tbl[`F_LOSS +: 2];
            device_memory_retention_pkg::EV_RESTORE: act = eff_tbl[`F_ON +: 2];
            device_memory_retention_pkg::EV_START:   act = eff_tbl[`F_S2R +: 2];
            device_memory_retention_pkg::EV_HALT:    act = eff_tbl[`F_R2S +: 2];
            default:                                 act = `ACT_KEEP;
        endcase
        if (event_i == device_memory_retention_pkg::EV_HALT && eff_tbl[`F_HOLD] && hold_i) begin
            act = `ACT_KEEP;
        end
        // battery-backed content is untrustworthy after a dead battery; flash content is not
        if (event_i == device_memory_retention_pkg::EV_RESTORE && TBL[`F_BATT] && backup_lost_i) begin
            act = `ACT_CLEAR;
        end
        data_next = data_reg;
        if (act == `ACT_CLEAR) begin
            data_next = '0;
        end else if (act == `ACT_INIT) begin
            data_next = DW'(INIT_VAL);
        end else if (latched && latch_clr_i) begin
            data_next = '0;
        end else if (wr_i && !(latched && latch_block_i)) begin
            for (int b = 0; b < DW / 8; b++) begin
                if (be_i[b]) begin
                    data_next[b*8 +: 8] = wdata_i[b*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_reg <= '0;
        end else begin
            data_reg <= data_next;
        end
    end

    assign rdata_o = data_reg;

endmodule

// ---- device_memory_retention_chk_asserts.sv ----
// checker for the retention controller: bus handshake and run sequencing at the top ports
// assumes one clock and a synchronous active-high reset; bound to the controller below
`timescale 1ns/1ns
module device_memory_retention_chk (
    input wire logic clk_i,              // system clock
    input wire logic rst_i,              // synchronous reset
    input wire logic wb_cyc_i,           // bus cycle
    input wire logic wb_stb_i,           // bus strobe
    input wire logic wb_ack_o,           // bus acknowledge
    input wire logic power_good_i,       // supply present
    input wire logic run_switch_i,       // run requested
    input wire logic first_scan_pulse_o, // first scan pulse
    input wire logic run_o               // scanning allowed
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_on_take_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged next cycle");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    run_entry_a: assert property ($rose(run_o) |-> $past(run_switch_i, 2) && $past(power_good_i, 2))
        else $error("run entered without request two cycles before");
    run_leave_a: assert property (run_o && !run_switch_i |=> !run_o) else $error("run not left");
    run_loss_a: assert property (!power_good_i |=> !run_o) else $error("run kept without power");
    pulse_entry_a: assert property ($rose(run_o) |-> first_scan_pulse_o) else $error("no first scan pulse");
    pulse_single_a: assert property (first_scan_pulse_o |=> !first_scan_pulse_o)
        else $error("first scan pulse too long");
    pulse_in_run_a: assert property (first_scan_pulse_o |-> run_o && !$past(run_o))
        else $error("first scan pulse outside run entry");
    run_cov: cover property ($rose(run_o));
    stop_cov: cover property ($fell(run_o) && power_good_i);
    loss_cov: cover property (run_o && !power_good_i);
endmodule
bind device_memory_retention_ctrl device_memory_retention_chk chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .power_good_i(power_good_i),
    .run_switch_i(run_switch_i), .first_scan_pulse_o(first_scan_pulse_o), .run_o(run_o));

// ---- device_memory_retention_ctrl.sv ----
// retention and clear sequencer for the device memories, with a classic wishbone slave
// assumes one clock, inputs synchronous to it, and a power-on reset
`timescale 1ns/1ns
`include "device_memory_retention_map.svh"
module device_memory_retention_ctrl #(
    parameter int unsigned DW = 16
) (
    input  wire logic        clk_i,              // system clock, 10 MHz
    input  wire logic        rst_i,              // synchronous reset, active high
    input  wire logic        wb_cyc_i,           // wishbone cycle
    input  wire logic        wb_stb_i,           // wishbone strobe
    input  wire logic        wb_we_i,            // wishbone write enable
    input  wire logic [7:0]  wb_adr_i,           // wishbone byte address
    input  wire logic [3:0]  wb_sel_i,           // wishbone byte selects
    input  wire logic [31:0] wb_dat_i,           // wishbone write data
    output logic      [31:0] wb_dat_o,           // wishbone read data
    output logic             wb_ack_o,           // wishbone acknowledge
    input  wire logic        power_good_i,       // supply present
    input  wire logic        run_switch_i,       // run requested
    input  wire logic        end_scan_i,         // end-of-scan processing pulse
    input  wire logic        cassette_present_i, // memory cassette mounted
    input  wire logic        battery_low_i,      // backup battery below holding level
    output logic             first_scan_pulse_o, // high in the first cycle of run, with run_o
    output logic             run_o               // program scanning allowed
);

    localparam int unsigned NCLS = `NUM_CLASSES;

    // per-class behaviour; index order matches the bus slots
    localparam logic [11:0] CLASS_TBL [NCLS] = '{
        `TBL_PROG_INT,  // built-in program, parameters, comments, file registers
        `TBL_FLASH,     // cassette program in flash
        `TBL_GENERAL,   // general data registers
        `TBL_LATCH_CFG, // latched data registers
        `TBL_SPECIAL,   // special registers and relays
        `TBL_SPEC_S2R,  // special subset cleared on stop-to-run
        `TBL_LATCH_FIX, // extension registers
        `TBL_FLASH,     // extension file registers
        `TBL_INDEX,     // index registers
        `TBL_GENERAL,   // 100 ms and 10 ms timer values
        `TBL_LATCH_FIX, // retentive timer values and contacts
        `TBL_GENERAL,   // general counter values
        `TBL_LATCH_CFG, // latched counter values
        `TBL_LATCH_FIX, // high speed counter values
        `TBL_BATT_KEEP, // clock data
        `TBL_GENERAL,   // input, output and general auxiliary relays
        `TBL_LATCH_CFG, // latched auxiliary relays
        `TBL_BATT_KEEP, // state relays and annunciators
        `TBL_GENERAL,   // timer contacts and coils
        `TBL_GENERAL    // counter contacts, counting and reset coils
    };

    // fsm group
    device_memory_retention_pkg::state_type state_reg;
    device_memory_retention_pkg::state_type state_next;
    logic first_reg;
    logic first_next;
    logic run_reg;
    logic run_next;
    logic bk_lost_reg;
    logic bk_lost_next;

    // control group
    logic            hold_reg;
    logic            hold_next;
    logic            clr_all_reg;
    logic            clr_all_next;
    logic [NCLS-1:0] latch_cfg_reg;
    logic [NCLS-1:0] latch_cfg_next;

    // bus group
    logic        ack_reg;
    logic        ack_next;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;

    device_memory_retention_pkg::event_type ev;
    logic          req;
    logic          wr_go;
    logic [4:0]    idx;
    logic [4:0]    eff_idx;
    logic          dev_ok;
    logic          latch_clr;
    logic [NCLS-1:0] cell_wr;
    logic [DW-1:0] cell_rd [NCLS];

    // the event code is a decode of the applying state, so it lasts exactly one cycle
    always_comb begin
        unique case (state_reg)
            device_memory_retention_pkg::ST_DOWN:  ev = device_memory_retention_pkg::EV_LOSS;
            device_memory_retention_pkg::ST_INIT:  ev = device_memory_retention_pkg::EV_RESTORE;
            device_memory_retention_pkg::ST_START: ev = device_memory_retention_pkg::EV_START;
            device_memory_retention_pkg::ST_HALT:  ev = device_memory_retention_pkg::EV_HALT;
            default:                               ev = device_memory_retention_pkg::EV_NONE;
        endcase
    end

    always_comb begin
        state_next   = state_reg;
        bk_lost_next = bk_lost_reg;
        unique case (state_reg)
            device_memory_retention_pkg::ST_OFF: begin
                if (power_good_i) begin
                    state_next   = device_memory_retention_pkg::ST_INIT;
                    bk_lost_next = battery_low_i;
                end
            end
            device_memory_retention_pkg::ST_INIT: begin
                state_next = device_memory_retention_pkg::ST_STOP;
            end
            device_memory_retention_pkg::ST_STOP: begin
                if (run_switch_i) begin
                    state_next = device_memory_retention_pkg::ST_START;
                end
            end
            device_memory_retention_pkg::ST_START: begin
                state_next = device_memory_retention_pkg::ST_RUN;
            end
            device_memory_retention_pkg::ST_RUN: begin
                if (!run_switch_i) begin
                    state_next = device_memory_retention_pkg::ST_HALT;
                end
            end
            device_memory_retention_pkg::ST_HALT: begin
                state_next = device_memory_retention_pkg::ST_STOP;
            end
            device_memory_retention_pkg::ST_DOWN: begin
                state_next = device_memory_retention_pkg::ST_OFF;
            end
            default: begin
                state_next = device_memory_retention_pkg::ST_DOWN;
            end
        endcase
        // supply loss overrides any step, but a clear already under way still completes
        if (!power_good_i && state_reg != device_memory_retention_pkg::ST_OFF
                && state_reg != device_memory_retention_pkg::ST_DOWN) begin
            state_next = device_memory_retention_pkg::ST_DOWN;
        end
        // run is only granted after the stop-to-run actions have been applied
        first_next = (state_reg == device_memory_retention_pkg::ST_START) && power_good_i;
        run_next   = (state_next == device_memory_retention_pkg::ST_RUN);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg   <= device_memory_retention_pkg::ST_OFF;
            first_reg   <= 1'b0;
            run_reg     <= 1'b0;
            bk_lost_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            first_reg   <= first_next;
            run_reg     <= run_next;
            bk_lost_reg <= bk_lost_next;
        end
    end

    // bus decode
    always_comb begin
        req   = wb_cyc_i && wb_stb_i && !ack_reg;
        wr_go = req && wb_we_i;
        idx   = wb_adr_i[`DEV_IDX_MSB:`DEV_IDX_LSB];
        // the program slot follows whichever memory currently holds the program
        eff_idx = (idx == `CLS_PROG_INT && cassette_present_i) ? `CLS_PROG_CAS : idx;
        dev_ok = wb_adr_i[`DEV_SEL_BIT] && (32'(idx) < NCLS) && (idx != `CLS_PROG_CAS)
                 && !(idx == `CLS_EXT_FILE && !cassette_present_i);
        latch_clr = clr_all_reg && end_scan_i;
    end

    always_comb begin
        hold_next      = hold_reg;
        clr_all_next   = clr_all_reg;
        latch_cfg_next = latch_cfg_reg;
        if (wr_go && wb_adr_i == `ADR_CTRL && wb_sel_i[0]) begin
            hold_next    = wb_dat_i[`CTRL_HOLD];
            clr_all_next = wb_dat_i[`CTRL_CLR_ALL];
        end
        if (wr_go && wb_adr_i == `ADR_LATCH_CFG) begin
            for (int b = 0; b < NCLS; b++) begin
                if (wb_sel_i[b / 8]) begin
                    latch_cfg_next[b] = wb_dat_i[b];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_reg      <= 1'b0;
            clr_all_reg   <= 1'b0;
            latch_cfg_reg <= NCLS'(`LATCH_CFG_RST);
        end else begin
            hold_reg      <= hold_next;
            clr_all_reg   <= clr_all_next;
            latch_cfg_reg <= latch_cfg_next;
        end
    end

    // one ack per request, read data captured with it; unmapped reads return zero
    always_comb begin
        ack_next = req;
        dat_next = dat_reg;
        if (req && !wb_we_i) begin
            dat_next = '0;
            if (wb_adr_i == `ADR_CTRL) begin
                dat_next[`CTRL_HOLD]    = hold_reg;
                dat_next[`CTRL_CLR_ALL] = clr_all_reg;
            end else if (wb_adr_i == `ADR_STATUS) begin
                dat_next[`STAT_STATE_LSB +: 3] = state_reg;
                dat_next[`STAT_CASSETTE]       = cassette_present_i;
                dat_next[`STAT_BK_LOST]        = bk_lost_reg;
                dat_next[`STAT_RUN]            = run_reg;
                dat_next[`STAT_BLOCK]          = clr_all_reg;
            end else if (wb_adr_i == `ADR_LATCH_CFG) begin
                dat_next[NCLS-1:0] = latch_cfg_reg;
            end else if (dev_ok) begin
                dat_next[DW-1:0] = cell_rd[eff_idx];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= '0;
        end else begin
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

    genvar i;
    generate
        for (i = 0; i < NCLS; i++) begin : g_cls
            assign cell_wr[i] = wr_go && dev_ok && (32'(eff_idx) == i);
            device_class_cell #(
                .DW       (DW),
                .TBL      (CLASS_TBL[i]),
                .INIT_VAL (`SPECIAL_INIT)
            ) u_cell (
                .clk_i         (clk_i),
                .rst_i         (rst_i),
                .event_i       (ev),
                .hold_i        (hold_reg),
                .as_general_i  (latch_cfg_reg[i]),
                .backup_lost_i (bk_lost_reg),
                .latch_clr_i   (latch_clr),
                .latch_block_i (clr_all_reg),
                .wr_i          (cell_wr[i]),
                .be_i          (wb_sel_i[1:0]),
                .wdata_i       (wb_dat_i[DW-1:0]),
                .rdata_o       (cell_rd[i])
            );
        end
    endgenerate

    assign wb_ack_o           = ack_reg;
    assign wb_dat_o           = dat_reg;
    assign first_scan_pulse_o = first_reg;
    assign run_o              = run_reg;

endmodule

// ---- device_memory_retention_map.svh ----
// offsets, field positions, class table words and reset values for the retention controller
// assumes inclusion by the package users; definitions only
`ifndef DEVICE_MEMORY_RETENTION_MAP_SVH
`define DEVICE_MEMORY_RETENTION_MAP_SVH

// bus map, byte addresses
`define ADR_CTRL       8'h00
`define ADR_STATUS     8'h04
`define ADR_LATCH_CFG  8'h08
`define DEV_SEL_BIT    7
`define DEV_IDX_MSB    6
`define DEV_IDX_LSB    2

// control register fields
`define CTRL_HOLD      0
`define CTRL_CLR_ALL   1

// status register fields
`define STAT_STATE_LSB 0
`define STAT_CASSETTE  4
`define STAT_BK_LOST   5
`define STAT_RUN       6
`define STAT_BLOCK     7

// class table word: four 2-bit actions then flags
`define F_LOSS         0
`define F_ON           2
`define F_S2R          4
`define F_R2S          6
`define F_HOLD         8
`define F_LATCHED      9
`define F_CFG          10
`define F_BATT         11
`define ACT_KEEP       2'h0
`define ACT_CLEAR      2'h1
`define ACT_INIT       2'h2

// device classes
`define NUM_CLASSES    20
`define CLS_PROG_INT   5'h00
`define CLS_PROG_CAS   5'h01
`define CLS_EXT_FILE   5'h07

// table words
`define TBL_GENERAL    12'h145
`define TBL_PROG_INT   12'h800
`define TBL_FLASH      12'h000
`define TBL_LATCH_CFG  12'he00
`define TBL_LATCH_FIX  12'ha00
`define TBL_SPECIAL    12'h009
`define TBL_SPEC_S2R   12'h019
`define TBL_INDEX      12'h005
`define TBL_BATT_KEEP  12'h800

// reset and initial values
`define SPECIAL_INIT   16'h0000
`define LATCH_CFG_RST  20'h00000

`endif

// ---- device_memory_retention_pkg.sv ----
// types shared by the retention controller and its per-class storage cell
// assumes no other package
package device_memory_retention_pkg;

    typedef enum logic [2:0] {
        ST_OFF   = 3'h0,
        ST_INIT  = 3'h1,
        ST_STOP  = 3'h3,
        ST_START = 3'h2,
        ST_RUN   = 3'h6,
        ST_HALT  = 3'h7,
        ST_DOWN  = 3'h4
    } state_type;

    typedef enum logic [2:0] {
        EV_NONE    = 3'h0,
        EV_LOSS    = 3'h1,
        EV_RESTORE = 3'h2,
        EV_START   = 3'h3,
        EV_HALT    = 3'h4
    } event_type;

endpackage

// ---- test_device_memory_retention_ctrl.sv ----
// self-checking bench for the retention controller, driving the bus and sequencer pins
// assumes the map chosen by the designer: device word of class c at 0x80 + 4*c
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module test_device_memory_retention_ctrl;
    // class masks: general clear, loss/restore clear, stop-to-run clear, battery-backed, latched
    localparam logic [19:0] GEN = 20'hc8a04, LOSS = 20'hc8b34, S2R = 20'h00020, BATT = 20'h37449, LAT = 20'h13448;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        pg = 1'b0, run_sw = 1'b0, es = 1'b0, cas = 1'b0, bl = 1'b0, ack, fsp, run;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'hf, sv = 4'hf;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [15:0] exp_mem [20];
    int          checks = 0, miscompares = 0, cycles = 0;
    always #50 clk_i = ~clk_i;
    device_memory_retention_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .power_good_i(pg),
        .run_switch_i(run_sw), .end_scan_i(es), .cassette_present_i(cas), .battery_low_i(bl),
        .first_scan_pulse_o(fsp), .run_o(run));
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            print_verdict();
        end
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= sv;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        `CHK("ack", 1'b1, ack)
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK($sformatf("adr %h", a), e, q)
    endtask
    function automatic logic [7:0] ca(input int c);
        return 8'h80 + 8'(c * 4);
    endfunction
    task automatic clr(input logic [19:0] m);
        for (int c = 0; c < 20; c++) if (m[c]) exp_mem[c] = 16'h0;
    endtask
    // class 1 has no slot and class 7 needs the cassette, so both are left out here
    task automatic fill(input logic [7:0] k);
        for (int c = 0; c < 20; c++) if (c != 1 && c != 7) begin
            bus(1'b1, ca(c), {16'hffff, k, 8'(c)});
            exp_mem[c] = {k, 8'(c)};
        end
    endtask
    task automatic check_all();
        for (int c = 0; c < 20; c++) if (c != 1 && c != 7) rd(ca(c), {16'h0, exp_mem[c]});
    endtask
    task automatic go_run();
        int n;
        n = 0;
        @(posedge clk_i);
        run_sw <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (fsp !== 1'b1 && n < 10);
        `CHK("first scan delay", 3, n)
        `CHK("run at first scan", 1'b1, run)
        @(posedge clk_i);
        `CHK("first scan single", 1'b0, fsp)
        clr(S2R);
    endtask
    task automatic go_stop(input logic [19:0] m);
        @(posedge clk_i);
        run_sw <= 1'b0;
        repeat (3) @(posedge clk_i);
        `CHK("run left", 1'b0, run)
        clr(m);
    endtask
    // the run switch drops with the supply so that the restore ends in stop, not in a fresh run
    task automatic power_cycle(input logic b);
        @(posedge clk_i);
        pg <= 1'b0;
        run_sw <= 1'b0;
        repeat (3) @(posedge clk_i);
        `CHK("run after loss", 1'b0, run)
        pg <= 1'b1;
        bl <= b;
        repeat (3) @(posedge clk_i);
        clr(LOSS);
    endtask
    task automatic t_basic();
        bus(1'b1, 8'h40, 32'h1234);
        rd(8'h40, 32'h0);
        rd(8'h84, 32'h0);
        rd(8'h04, 32'h3);
        sv = 4'h1;
        bus(1'b1, ca(2), 32'habcd);
        sv = 4'hf;
        rd(ca(2), 32'h00cd);
        fill(8'ha5);
        check_all();
        $display("basic done");
    endtask
    task automatic t_run_stop();
        go_run();
        check_all();
        bus(1'b1, 8'h00, 32'h1);
        go_stop(20'h0);
        check_all();
        bus(1'b1, 8'h00, 32'h0);
        fill(8'h3c);
        go_run();
        go_stop(GEN);
        check_all();
        $display("run stop done");
    endtask
    task automatic t_power();
        go_run();
        fill(8'h5a);
        power_cycle(1'b0);
        check_all();
        rd(8'h04, 32'h3);
        $display("power done");
    endtask
    task automatic t_cfg();
        bus(1'b1, 8'h08, 32'h14008);
        fill(8'h69);
        go_run();
        // classes 3 and 16 become general; clock data (14) is fixed and ignores its bit
        go_stop(GEN | 20'h10008);
        check_all();
        bus(1'b1, 8'h08, 32'h0);
        $display("latch config done");
    endtask
    task automatic t_clear_all();
        fill(8'h96);
        bus(1'b1, 8'h00, 32'h2);
        rd(8'h04, 32'h83);
        @(posedge clk_i);
        es <= 1'b1;
        @(posedge clk_i);
        es <= 1'b0;
        clr(LAT);
        bus(1'b1, ca(3), 32'h1234);
        check_all();
        bus(1'b1, 8'h00, 32'h0);
        $display("clear all done");
    endtask
    task automatic t_cassette();
        bus(1'b1, ca(7), 32'h7777);
        rd(ca(7), 32'h0);
        @(posedge clk_i);
        cas <= 1'b1;
        bus(1'b1, ca(7), 32'h7777);
        rd(ca(0), 32'h0);
        bus(1'b1, ca(0), 32'h1111);
        power_cycle(1'b1);
        rd(ca(0), 32'h1111);
        rd(ca(7), 32'h7777);
        rd(8'h04, 32'h33);
        @(posedge clk_i);
        cas <= 1'b0;
        clr(BATT);
        check_all();
        $display("cassette done");
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        pg <= 1'b1;
        repeat (4) @(posedge clk_i);
        t_basic();
        t_run_stop();
        t_power();
        t_cfg();
        t_clear_all();
        t_cassette();
        print_verdict();
    end
endmodule
